/* verilog/swd_pkg.sv */
// Purpose: Shared constants and types of the watchdog and reset status block
// Assumes: 100 MHz clock, register access already decoded from the serial port
// Notes: Period table, mode codes and reset cause codes live here only
package swd_pkg;
    // Register addresses
    localparam logic [6:0] ADDR_WD_CTRL = 7'h00;
    localparam logic [6:0] ADDR_MAIN_STAT = 7'h03;

    // Watchdog mode selection codes (redundant, two bits apart)
    localparam logic [2:0] MODE_AUTO = 3'h1;
    localparam logic [2:0] MODE_TMO = 3'h2;
    localparam logic [2:0] MODE_WIN = 3'h4;

    // Period selection codes
    localparam logic [3:0] PER_8 = 4'h8;
    localparam logic [3:0] PER_16 = 4'h1;
    localparam logic [3:0] PER_32 = 4'h2;
    localparam logic [3:0] PER_64 = 4'hb;
    localparam logic [3:0] PER_128 = 4'h4;
    localparam logic [3:0] PER_256 = 4'hd;
    localparam logic [3:0] PER_1024 = 4'he;
    localparam logic [3:0] PER_4096 = 4'h7;
    localparam logic [3:0] PER_DEFAULT = PER_128;

    // Period lengths in milliseconds
    localparam logic [12:0] MS_8 = 13'h0008;
    localparam logic [12:0] MS_16 = 13'h0010;
    localparam logic [12:0] MS_32 = 13'h0020;
    localparam logic [12:0] MS_64 = 13'h0040;
    localparam logic [12:0] MS_128 = 13'h0080;
    localparam logic [12:0] MS_256 = 13'h0100;
    localparam logic [12:0] MS_1024 = 13'h0400;
    localparam logic [12:0] MS_4096 = 13'h1000;

    // Timing: one millisecond and the clock period, both in ns
    localparam int NS_PER_MS = 1000000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int CYC_PER_MS = NS_PER_MS / CLK_PERIOD_NS;

    // Reset cause codes
    localparam logic [4:0] RC_POWER_ON = 5'h00;
    localparam logic [4:0] RC_CAN_WAKE = 5'h01;
    localparam logic [4:0] RC_PIN_WAKE = 5'h04;
    localparam logic [4:0] RC_SLEEP_OVF = 5'h0c;
    localparam logic [4:0] RC_DIAG_WAKE = 5'h0d;
    localparam logic [4:0] RC_EARLY_TRIG = 5'h0e;
    localparam logic [4:0] RC_WD_OVF = 5'h0f;
    localparam logic [4:0] RC_BAD_WD_MODE = 5'h10;
    localparam logic [4:0] RC_EXT_RESET = 5'h11;
    localparam logic [4:0] RC_OTP_EXIT = 5'h12;
    localparam logic [4:0] RC_CORE_UV = 5'h13;
    localparam logic [4:0] RC_BAD_SLEEP = 5'h14;

    // Watchdog control register layout
    typedef struct packed {
        logic [2:0] mode;
        logic rsv;
        logic [3:0] period;
    } swd_wdctl_t;

    // Main status register layout
    typedef struct packed {
        logic rsv;
        logic otw;
        logic normal_entered_flag;
        logic [4:0] cause;
    } swd_mstat_t;

    // Chip operating mode as seen by the watchdog
    typedef struct packed {
        logic normal;
        logic standby;
        logic sleep;
    } swd_chip_t;

    // Reset causes reported by the surrounding chip logic
    typedef struct packed {
        logic can_wake;
        logic pin_wake;
        logic diag_wake;
        logic ext_reset;
        logic otp_exit;
        logic core_uv;
        logic bad_sleep;
    } swd_cause_t;

    // Effective watchdog state
    typedef enum logic [2:0] {
        WD_OFF = 3'b001,
        WD_TMO = 3'b010,
        WD_WIN = 3'b100
    } swd_wdst_t;
endpackage

/* verilog/swd_watchdog.sv */
// Purpose: Watchdog supervisor with main status and reset cause register
// Assumes: Register strobes and chip mode come from logic on clk
// Notes: Overtemperature warning arrives from an analog comparator
//
// Contract
// - Bit 6 shows overtemperature warning level
// - Bit 5 set until first Normal entry
// - Cause codes for power-on and sleep wakes
// - Cause codes for watchdog early, overflow, illegal
// - Cause codes for external, overtemp, undervoltage, sleep
// - Window, Timeout, Autonomous; Window only in Normal
// - Window restart only inside open window
// - Timeout restarts on trigger any time
// - Window selection runs Timeout until Normal
// - Mode change in Normal forces reset
// - Eight periods, default 128 ms
// - Redundant period code decode
// - Valid control write restarts timer
// - New mode and period apply at once
// - Mode decode and default by development bit
// - Off when forced normal or other modes
// - Autonomous runs only under listed conditions
// - Undefined codes abandon write, SPI fail
// - Window early trigger or overflow resets
// - Timeout overflow captures fail, resets if pending
`timescale 1ns/1ps
module swd_watchdog #(
    parameter int MS_CYCLES = swd_pkg::CYC_PER_MS
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [6:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire swd_pkg::swd_chip_t chip_mode,
    input wire logic rxd_low,
    input wire logic forced_normal_cfg,
    input wire logic sw_dev_cfg,
    input wire logic overtemp_pin,
    input wire swd_pkg::swd_cause_t cause_evt,
    input wire logic wd_fail_en,
    input wire logic wd_fail_pending,
    input wire logic spi_fail_en,
    output logic sys_reset_req,
    output logic wd_fail_capture,
    output logic spi_fail_capture,
    output logic wd_wake,
    output logic [1:0] wd_status
);
    import swd_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Decode helpers

    // Period code to milliseconds; zero marks an undefined code
    function automatic logic [12:0] period_ms(input logic [3:0] code);
        case (code)
            PER_8: period_ms = MS_8;
            PER_16: period_ms = MS_16;
            PER_32: period_ms = MS_32;
            PER_64: period_ms = MS_64;
            PER_128: period_ms = MS_128;
            PER_256: period_ms = MS_256;
            PER_1024: period_ms = MS_1024;
            PER_4096: period_ms = MS_4096;
            default: period_ms = '0;
        endcase
    endfunction

    function automatic logic mode_ok(input logic [2:0] code);
        mode_ok = (code == MODE_AUTO) || (code == MODE_TMO) || (code == MODE_WIN);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State

    logic [2:0] mode_ff;
    logic [3:0] period_ff;
    logic init_ff;
    logic [31:0] cnt_ff;
    logic [4:0] cause_ff;
    logic nms_ff;
    logic otw_ff;
    logic ot_s1_ff;
    logic ot_s2_ff;
    logic ot_s3_ff;
    logic [7:0] rdata_ff;
    logic rst_req_ff;
    logic wdf_ff;
    logic spif_ff;
    logic wake_ff;

    swd_wdctl_t wr_ctl;
    swd_mstat_t mstat;
    swd_wdst_t wd_state;
    logic [31:0] per_cyc;
    logic [31:0] half_cyc;
    logic ctl_wr;
    logic codes_ok;
    logic mode_change_bad;
    logic wr_ok;
    logic early;
    logic ovf;
    logic win_fail;
    logic tmo_reset;
    logic tmo_capture;
    logic sleep_ovf;
    logic [4:0] nxt_cause;
    logic [31:0] nxt_cnt;

    ////////////////////////////////////////////////////////////////////////
    // Effective watchdog state from selection and chip mode

    // Window needs Normal; otherwise a Window selection times out
    assign wd_state = forced_normal_cfg ? WD_OFF :
        (mode_ff == MODE_WIN) ? (chip_mode.normal ? WD_WIN :
            ((chip_mode.standby || chip_mode.sleep) ? WD_TMO : WD_OFF)) :
        (mode_ff == MODE_TMO) ?
            ((chip_mode.normal || chip_mode.standby || chip_mode.sleep) ? WD_TMO : WD_OFF) :
        (sw_dev_cfg ? WD_OFF :
            ((chip_mode.normal || (chip_mode.standby && rxd_low)) ? WD_TMO : WD_OFF));

    ////////////////////////////////////////////////////////////////////////
    // Control write classification

    assign wr_ctl = reg_wdata;
    assign ctl_wr = reg_wr && (reg_addr == ADDR_WD_CTRL) && !init_ff;
    assign codes_ok = mode_ok(wr_ctl.mode) && (period_ms(wr_ctl.period) != '0);
    // A mode change while Normal is a host fault, caught here
    assign mode_change_bad = ctl_wr && codes_ok && chip_mode.normal
        && (wr_ctl.mode != mode_ff);
    assign wr_ok = ctl_wr && codes_ok && !mode_change_bad;

    ////////////////////////////////////////////////////////////////////////
    // Timer thresholds and events

    // Product stays below 2^31 for the longest period at 100 MHz
    assign per_cyc = 32'(period_ms(period_ff)) * 32'(MS_CYCLES);
    assign half_cyc = per_cyc >> 1;
    assign early = wr_ok && (wd_state == WD_WIN) && (cnt_ff < half_cyc);
    assign ovf = (wd_state != WD_OFF) && (cnt_ff >= per_cyc - 32'h1);
    assign win_fail = early || (ovf && (wd_state == WD_WIN));
    assign tmo_reset = ovf && (wd_state == WD_TMO) && wd_fail_pending;
    assign tmo_capture = ovf && (wd_state == WD_TMO) && !wd_fail_pending;
    assign sleep_ovf = tmo_capture && chip_mode.sleep;

    // Timer: cleared while off, on a trigger and on overflow
    assign nxt_cnt = (wd_state == WD_OFF) ? '0 :
        (wr_ok || ovf) ? '0 :
        cnt_ff + 32'h1;

    // Cause priority: watchdog faults first, then chip events
    assign nxt_cause = early ? RC_EARLY_TRIG :
        (win_fail || tmo_reset) ? RC_WD_OVF :
        mode_change_bad ? RC_BAD_WD_MODE :
        sleep_ovf ? RC_SLEEP_OVF :
        cause_evt.ext_reset ? RC_EXT_RESET :
        cause_evt.otp_exit ? RC_OTP_EXIT :
        cause_evt.core_uv ? RC_CORE_UV :
        cause_evt.bad_sleep ? RC_BAD_SLEEP :
        cause_evt.can_wake ? RC_CAN_WAKE :
        cause_evt.pin_wake ? RC_PIN_WAKE :
        cause_evt.diag_wake ? RC_DIAG_WAKE :
        cause_ff;

    ////////////////////////////////////////////////////////////////////////
    // Configuration: default loaded one edge after reset release

    // Development bit is sampled by a clocked load, not by the reset
    always_ff @(posedge clk) begin
        if (srst) begin
            init_ff <= 1'b1;
            mode_ff <= MODE_TMO;
            period_ff <= PER_DEFAULT;
        end else if (init_ff) begin
            init_ff <= 1'b0;
            mode_ff <= sw_dev_cfg ? MODE_AUTO : MODE_TMO;
        end else if (wr_ok) begin
            mode_ff <= wr_ctl.mode;
            period_ff <= wr_ctl.period;
        end
    end

    // Timer and reset cause
    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_ff <= '0;
            cause_ff <= RC_POWER_ON;
        end else begin
            cnt_ff <= nxt_cnt;
            cause_ff <= nxt_cause;
        end
    end

    // Normal-entered flag: set by power-up, cleared on Normal
    always_ff @(posedge clk) begin
        if (srst) begin
            nms_ff <= 1'b1;
        end else if (chip_mode.normal) begin
            nms_ff <= 1'b0;
        end
    end

    // Warning pin: three stages, accepted when last two agree
    always_ff @(posedge clk) begin
        if (srst) begin
            ot_s1_ff <= 1'b0;
            ot_s2_ff <= 1'b0;
            ot_s3_ff <= 1'b0;
            otw_ff <= 1'b0;
        end else begin
            ot_s1_ff <= overtemp_pin;
            ot_s2_ff <= ot_s1_ff;
            ot_s3_ff <= ot_s2_ff;
            if (ot_s2_ff == ot_s3_ff) begin
                otw_ff <= ot_s3_ff;
            end
        end
    end

    // Event pulses, one cycle each
    always_ff @(posedge clk) begin
        if (srst) begin
            rst_req_ff <= 1'b0;
            wdf_ff <= 1'b0;
            spif_ff <= 1'b0;
            wake_ff <= 1'b0;
        end else begin
            rst_req_ff <= win_fail || tmo_reset || mode_change_bad;
            wdf_ff <= wd_fail_en && (win_fail || tmo_capture);
            spif_ff <= spi_fail_en && ctl_wr && !codes_ok;
            wake_ff <= sleep_ovf;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register read

    assign mstat = '{rsv: 1'b0, otw: otw_ff, normal_entered_flag: nms_ff, cause: cause_ff};

    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_ff <= '0;
        end else if (reg_rd && (reg_addr == ADDR_WD_CTRL)) begin
            rdata_ff <= {mode_ff, 1'b0, period_ff};
        end else if (reg_rd && (reg_addr == ADDR_MAIN_STAT)) begin
            rdata_ff <= mstat;
        end else if (reg_rd) begin
            rdata_ff <= '0;
        end
    end

    assign reg_rdata = rdata_ff;
    assign sys_reset_req = rst_req_ff;
    assign wd_fail_capture = wdf_ff;
    assign spi_fail_capture = spif_ff;
    assign wd_wake = wake_ff;
    // Window halves reported as 01 and 10, off as 00
    assign wd_status = (wd_state == WD_OFF) ? 2'h0 : (cnt_ff < half_cyc) ? 2'h1 : 2'h2;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence s_early_write;
        wr_ok && (wd_state == WD_WIN) && (cnt_ff < half_cyc);
    endsequence

    sequence s_reset_for(logic [4:0] code);
        sys_reset_req && (cause_ff == code);
    endsequence

    a_early_trig: assert property (s_early_write |=> s_reset_for(RC_EARLY_TRIG))
        else $error("early window trigger did not reset");
    a_bad_mode_chg: assert property (mode_change_bad |=> s_reset_for(RC_BAD_WD_MODE)
        ##0 (mode_ff == $past(mode_ff)))
        else $error("mode change in Normal not caught");
    a_bad_code: assert property (ctl_wr && !codes_ok |=>
        (spi_fail_capture == $past(spi_fail_en)) && $stable(period_ff) && $stable(mode_ff))
        else $error("undefined code not abandoned");
    a_off_clear: assert property ((wd_state == WD_OFF) |=> (cnt_ff == '0))
        else $error("timer runs while off");
    a_win_normal: assert property ((wd_state == WD_WIN) |-> chip_mode.normal)
        else $error("window active outside Normal");
    a_forced_off: assert property (forced_normal_cfg |=> (cnt_ff == '0) && !wd_fail_capture && !wd_wake)
        else $error("watchdog on under forced normal");
    a_trig_restart: assert property (wr_ok && !early && (wd_state != WD_OFF)
        ##1 (wd_state != WD_OFF) |-> (cnt_ff == '0))
        else $error("valid write did not restart timer");
    a_nms_clear: assert property (chip_mode.normal |=> !nms_ff [*2])
        else $error("normal flag not cleared");
    a_otw_follow: assert property ((ot_s2_ff == ot_s3_ff) |=> (otw_ff == $past(ot_s3_ff)))
        else $error("warning status not following");
    a_tmo_pending: assert property (tmo_reset |=> s_reset_for(RC_WD_OVF))
        else $error("pending fail overflow did not reset");
    a_tmo_capture: assert property (tmo_capture && wd_fail_en |=> wd_fail_capture && !sys_reset_req)
        else $error("timeout overflow not captured");
endmodule

/* verif/swd_host.sv */
// Purpose: Host model issuing decoded register accesses to the watchdog
// Assumes: Serial framing already stripped, one strobe per access
// Notes: Drives just after a rising edge, holds until the sampling edge
`timescale 1ns/1ps
module swd_host (
    input wire logic clk,
    output logic reg_wr,
    output logic reg_rd,
    output logic [6:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    import swd_pkg::*;
    ////////////////////////////////////////////////////////////////
    // Idle bus at time zero
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 7'h7f;
        reg_wdata = 8'h00;
    end
    // One write; mode changes belong in Standby only
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d; // Stale data must never look valid
    endtask
    // One read; data taken one edge after the strobe is sampled
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        @(posedge clk);
        d = reg_rdata;
    endtask
endmodule

/* verif/tb_top.sv */
// Purpose: Self-checking bench for the watchdog and reset status block
// Assumes: MS_CYCLES shortened to 10, so 8 ms is 80 cycles
// Notes: Pulses are sampled 1 ns after the edge that launches them
`timescale 1ns/1ps
module tb_top;
    import swd_pkg::*;
    localparam swd_chip_t NORM = 3'b100;
    localparam swd_chip_t STBY = 3'b010;
    localparam swd_chip_t SLP = 3'b001;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic reg_wr, reg_rd;
    logic [6:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, d;
    swd_chip_t chip_mode = STBY;
    swd_cause_t cause_evt = '0;
    logic rxd_low = 1'b0, fn_cfg = 1'b0, sd_cfg = 1'b0, otp = 1'b0;
    logic fail_en = 1'b1, pend = 1'b0, spi_en = 1'b1;
    logic sys_reset_req, wd_fail_capture, spi_fail_capture, wd_wake;
    logic [1:0] wd_status;
    wire [3:0] pl = {spi_fail_capture, wd_wake, wd_fail_capture, sys_reset_req};
    int miscompares = 0;
    int n_compared = 0;
    logic [4:0] ctab [7] = '{5'h01, 5'h04, 5'h0d, 5'h11, 5'h12, 5'h13, 5'h14};
    logic [7:0] ptab [8] = '{8'h48, 8'h41, 8'h42, 8'h4b, 8'h44, 8'h4d, 8'h4e, 8'h47};
    ////////////////////////////////////////////////////////////////
    always #5 clk = ~clk;
    swd_host swd_host_inst (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
    swd_watchdog #(.MS_CYCLES(10)) swd_watchdog_inst (.clk(clk), .srst(srst),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .chip_mode(chip_mode),
        .rxd_low(rxd_low), .forced_normal_cfg(fn_cfg), .sw_dev_cfg(sd_cfg),
        .overtemp_pin(otp), .cause_evt(cause_evt), .wd_fail_en(fail_en),
        .wd_fail_pending(pend), .spi_fail_en(spi_en),
        .sys_reset_req(sys_reset_req), .wd_fail_capture(wd_fail_capture),
        .spi_fail_capture(spi_fail_capture), .wd_wake(wd_wake),
        .wd_status(wd_status));
    ////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        n_compared++;
        if (s !== e) begin
            miscompares++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic rc(input logic [6:0] a, input logic [7:0] e);
        swd_host_inst.rd(a, d);
        chk(d, e);
    endtask
    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Cycles until pulse k; a lost pulse ends the run
    task automatic cnt(input int k, input int e);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (pl[k] !== 1'b1 && n < 400);
        if (n >= 400) begin
            miscompares++;
            wrap_up();
        end else begin
            chk(n[15:0], e[15:0]);
        end
    endtask
    task automatic go(input swd_chip_t m);
        @(posedge clk);
        chip_mode <= m;
    endtask
    task automatic do_reset;
        @(posedge clk);
        srst <= 1'b1;
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    ////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        do_reset();
        rc(ADDR_MAIN_STAT, 8'h20);
        rc(ADDR_WD_CTRL, 8'h44);
        rc(7'h10, 8'h00);
        @(posedge clk);
        otp <= 1'b1;
        repeat (6) @(posedge clk);
        rc(ADDR_MAIN_STAT, 8'h60);
        otp <= 1'b0;
        repeat (6) @(posedge clk);
        rc(ADDR_MAIN_STAT, 8'h20);
        $display("test status done");
        // Every period code, then undefined codes that must not stick
        for (int i = 0; i < 8; i++) begin
            swd_host_inst.wr(ADDR_WD_CTRL, ptab[i]);
            rc(ADDR_WD_CTRL, ptab[i]);
        end
        swd_host_inst.wr(ADDR_WD_CTRL, 8'h68);
        #1 chk(spi_fail_capture, 1'b1);
        swd_host_inst.wr(ADDR_WD_CTRL, 8'h49);
        #1 chk(spi_fail_capture, 1'b1);
        rc(ADDR_WD_CTRL, 8'h47);
        swd_host_inst.wr(ADDR_WD_CTRL, 8'h58);
        rc(ADDR_WD_CTRL, 8'h48);
        $display("test codes done");
        // Timeout: retrigger mid-period, then full 8 ms to overflow
        swd_host_inst.wr(ADDR_WD_CTRL, 8'h48);
        #1 chk(wd_status, 2'b01);
        repeat (50) @(posedge clk);
        #1 chk(wd_status, 2'b10);
        swd_host_inst.wr(ADDR_WD_CTRL, 8'h48);
        cnt(1, 80);
        go(SLP);
        swd_host_inst.wr(ADDR_WD_CTRL, 8'h48);
        cnt(2, 80);
        rc(ADDR_MAIN_STAT, 8'h2c);
        go(STBY);
        pend <= 1'b1;
        swd_host_inst.wr(ADDR_WD_CTRL, 8'h48);
        cnt(0, 80);
        rc(ADDR_MAIN_STAT, 8'h2f);
        pend <= 1'b0;
        $display("test timeout done");
        // Window selected in Standby still behaves as Timeout
        swd_host_inst.wr(ADDR_WD_CTRL, 8'h88);
        cnt(1, 80);
        go(NORM);
        repeat (45) @(posedge clk);
        swd_host_inst.wr(ADDR_WD_CTRL, 8'h88);
        #1 chk(sys_reset_req, 1'b0);
        cnt(0, 80);
        rc(ADDR_MAIN_STAT, 8'h0f);
        swd_host_inst.wr(ADDR_WD_CTRL, 8'h88);
        #1 chk(sys_reset_req, 1'b1);
        chk(wd_fail_capture, 1'b1);
        rc(ADDR_MAIN_STAT, 8'h0e);
        swd_host_inst.wr(ADDR_WD_CTRL, 8'h48);
        #1 chk(sys_reset_req, 1'b1);
        rc(ADDR_MAIN_STAT, 8'h10);
        rc(ADDR_WD_CTRL, 8'h88);
        $display("test window done");
        // Causes reported by the surrounding chip
        for (int i = 0; i < 7; i++) begin
            @(posedge clk);
            cause_evt <= swd_cause_t'(7'h40 >> i);
            @(posedge clk);
            cause_evt <= '0;
            rc(ADDR_MAIN_STAT, {3'h0, ctab[i]});
        end
        // Off states
        fn_cfg <= 1'b1;
        repeat (2) @(posedge clk);
        #1 chk(wd_status, 2'b00);
        go(STBY);
        fn_cfg <= 1'b0;
        swd_host_inst.wr(ADDR_WD_CTRL, 8'h24);
        repeat (2) @(posedge clk);
        #1 chk(wd_status, 2'b00);
        @(posedge clk);
        rxd_low <= 1'b1;
        repeat (2) @(posedge clk);
        #1 chk(wd_status, 2'b01);
        @(posedge clk);
        sd_cfg <= 1'b1;
        do_reset();
        rc(ADDR_WD_CTRL, 8'h24);
        $display("test off done");
        wrap_up();
    end
endmodule
